// file: inc/video_adc_regs.vh
// Offsets, field positions, reset values and counts of the register bank.
`ifndef VIDEO_ADC_REGS_VH
`define VIDEO_ADC_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_SILICON_REVISION 8'h00
`define OFS_DIV_HIGH 8'h01
`define OFS_DIV_LOW 8'h02
`define OFS_CLKGEN_CTRL 8'h03
`define OFS_LINES_HIGH 8'h26
`define OFS_LINES_LOW 8'h27
`define OFS_TEST_ONE 8'h28
`define OFS_TEST_TWO 8'h29
`define OFS_TEST_RB_ONE 8'h2A
`define OFS_TEST_RB_TWO 8'h2B
`define OFS_OFFSET_HOLD 8'h2C
`define OFS_TEST_FIVE 8'h2D
`define OFS_TEST_SIX 8'h2E
`define OFS_GAIN_MATCH 8'h3C

// ****************************************
// Reset values
// ****************************************
`define RST_DIV_HIGH 8'h69
`define RST_DIV_LOW 8'hD0
`define RST_CLKGEN_CTRL 8'h48
`define RST_TEST_ONE 8'hBF
`define RST_TEST_TWO 8'h02
`define RST_OFFSET_HOLD 8'h00
`define RST_TEST_FIVE 8'hF0
`define RST_TEST_SIX 8'hF0
`define RST_GAIN_MATCH 8'h00
`define RST_TEST_READBACK 8'h00
`define RST_DIVIDE_RATIO 12'h69D

// ****************************************
// Field positions and codes
// ****************************************
`define DIV_LOW_MSB 7
`define DIV_LOW_LSB 4
`define BAND_MSB 7
`define BAND_LSB 6
`define PUMP_MSB 5
`define PUMP_LSB 3
`define EXT_CLK_BIT 2
`define OFFSET_CONT_BIT 4
`define GAIN_HOLD_BIT 3
`define GAIN_EN_MSB 2
`define GAIN_EN_LSB 0
`define GAIN_EN_CODE 3'h6
`define DIV_MIN 12'h002
`define LINE_COUNT_MAX 12'hFFF

// ****************************************
// Serial port
// ****************************************
`define SERIAL_DEV_ADDR 7'h4C
`define SERIAL_BIT_COUNT 4'h8

`endif

// file: rtl/serial_ctrl_slave.v
// Two-wire serial control port slave with auto-incrementing register pointer.
`timescale 1ns/1ps
`default_nettype none
`include "video_adc_regs.vh"

module serial_ctrl_slave (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output reg wr_stb,
  output reg [7:0] wr_addr,
  output reg [7:0] wr_data,
  output wire [7:0] rd_addr,
  input wire [7:0] rd_data
);

  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_ACK_A = 9'h004;
  localparam [8:0] ST_REG = 9'h008;
  localparam [8:0] ST_ACK_R = 9'h010;
  localparam [8:0] ST_WDAT = 9'h020;
  localparam [8:0] ST_ACK_W = 9'h040;
  localparam [8:0] ST_RDAT = 9'h080;
  localparam [8:0] ST_RACK = 9'h100;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [2:0] scl_s_r;
  reg [2:0] sda_s_r;
  reg scl_f_r;
  reg sda_f_r;
  reg scl_d_r;
  reg sda_d_r;

  // Three stages; a level is accepted only once the last two agree, which rejects glitches.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
    end
  end

  wire scl_rise = scl_f_r & ~scl_d_r;
  wire scl_fall = ~scl_f_r & scl_d_r;
  wire start_c = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
  wire stop_c = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

  // ****************************************
  // Protocol engine
  // ****************************************
  reg [8:0] st_r;
  reg [3:0] cnt_r;
  reg [7:0] sr_r;
  reg [7:0] ptr_r;
  reg [7:0] tx_r;
  reg rw_r;
  reg mack_r;

  assign rd_addr = ptr_r;

  // Bits are sampled on the rising clock edge and driven after the falling one.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        st_r <= ST_ADDR;
        cnt_r <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        st_r <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == ST_RACK) begin
          mack_r <= ~sda_f_r;
          ptr_r <= ptr_r + 8'h01;
        end else if ((st_r == ST_ADDR) || (st_r == ST_REG) || (st_r == ST_WDAT)) begin
          sr_r <= {sr_r[6:0], sda_f_r};
          cnt_r <= cnt_r + 4'h1;
        end
      end else if (scl_fall) begin
        case (st_r)
          ST_ADDR: begin
            if (cnt_r == `SERIAL_BIT_COUNT) begin
              if (sr_r[7:1] == `SERIAL_DEV_ADDR) begin
                rw_r <= sr_r[0];
                sda_oe <= 1'b1;
                st_r <= ST_ACK_A;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              tx_r <= rd_data;
              sda_oe <= ~rd_data[7];
              st_r <= ST_RDAT;
            end else begin
              sda_oe <= 1'b0;
              st_r <= ST_REG;
            end
          end
          ST_REG: begin
            if (cnt_r == `SERIAL_BIT_COUNT) begin
              ptr_r <= sr_r;
              sda_oe <= 1'b1;
              st_r <= ST_ACK_R;
            end
          end
          ST_WDAT: begin
            if (cnt_r == `SERIAL_BIT_COUNT) begin
              wr_stb <= 1'b1;
              wr_addr <= ptr_r;
              wr_data <= sr_r;
              sda_oe <= 1'b1;
              st_r <= ST_ACK_W;
            end
          end
          ST_ACK_R, ST_ACK_W: begin
            if (st_r == ST_ACK_W) ptr_r <= ptr_r + 8'h01;
            sda_oe <= 1'b0;
            cnt_r <= 4'h0;
            st_r <= ST_WDAT;
          end
          ST_RDAT: begin
            if (cnt_r == 4'h7) begin
              sda_oe <= 1'b0;
              st_r <= ST_RACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe <= ~tx_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
          ST_RACK: begin
            cnt_r <= 4'h0;
            if (mack_r) begin
              tx_r <= rd_data;
              sda_oe <= ~rd_data[7];
              st_r <= ST_RDAT;
            end else begin
              st_r <= ST_IDLE;
            end
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/video_adc_clock_calib_regs.v
// Control and status register bank for clock generation and calibration of a video digitizer.
`timescale 1ns/1ps
`default_nettype none
`include "video_adc_regs.vh"

// Operation
// R1 - Ratio is 12 bits: high register, then low register bits 7:4.
// R2 - Wide settings apply only on their low register write.
// R3 - Divider takes ratios 2 through 4095.
// R4 - Power-up ratio 1693, high register 0x69.
// R5 - Pixel clock locks to Hsync; ratio sets periods per line.
// R6 - Band bits 7:6 select pixel-rate band, default 01.
// R7 - Post-divider follows the band automatically.
// R8 - Pump bits 5:3 select 50 to 1500, default 001.
// R9 - Bit 2 picks internal PLL (0) or external clock (1).
// R10 - External clock ignores ratio, keeps phase adjustment.
// R11 - Line count low four bits read at 0x27 bits 7:4.
// R12 - Line count upper eight bits read at 0x26.
// R13 - Host writes 0xBF and 0x02 to test registers one, two.
// R14 - Host writes 0xE8 to 0x2D and 0xE0 to 0x2E.
// R15 - Offset bit 4: 0 updates once, 1 continuously.
// R16 - Host keeps other offset-hold bits at default.
// R17 - Gain hold bit: 0 freezes gain, 1 updates.
// R18 - Gain bits 2:0: 000 disables, 110 enables matching.
// R19 - Host keeps auto-gain bits 7:4 at default.
// R20 - Address 0x00 returns the 8-bit revision.
// R21 - High bits wait in a shadow until the low write.
module video_adc_clock_calib_regs #(
  // Arbitrary revision value.
  parameter [7:0] REVISION = 8'h01
) (
  input wire clk,
  input wire arst_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire hsync_in,
  input wire vsync_in,
  output reg [11:0] pixel_clock_divide_ratio,
  output reg pll_divider_enable,
  output reg phase_adjust_enable,
  output reg [1:0] oscillator_band_select,
  output reg [1:0] post_divider_log2,
  output reg [2:0] pump_current_code,
  output reg [10:0] pump_current_ua,
  output reg external_pixel_clock_select,
  output reg auto_offset_continuous,
  output reg gain_matching_continuous,
  output reg gain_matching_enable,
  output reg [7:0] test_setting_one,
  output reg [7:0] test_setting_two,
  output reg [7:0] test_setting_five,
  output reg [7:0] test_setting_six
);

  // ****************************************
  // Reset release
  // ****************************************
  reg [1:0] rst_s_r;
  wire rst_n;

  // Assert at once, release two edges later so no flop leaves reset mid-cycle.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s_r <= 2'h0;
    end else begin
      rst_s_r <= {rst_s_r[0], 1'b1};
    end
  end

  assign rst_n = rst_s_r[1];

  // ****************************************
  // Serial port
  // ****************************************
  wire wr_stb;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire [7:0] rd_addr;
  reg [7:0] rd_data;

  serial_ctrl_slave u_port (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ****************************************
  // Sync pin synchronisers
  // ****************************************
  wire [1:0] sync_pins = {vsync_in, hsync_in};
  reg [2:0] sync_s_r [0:1];
  reg [1:0] sync_f_r;
  reg [1:0] sync_d_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      // A level is taken once the second and third stages agree.
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_s_r[gi] <= 3'h0;
          sync_f_r[gi] <= 1'b0;
          sync_d_r[gi] <= 1'b0;
        end else begin
          sync_s_r[gi] <= {sync_s_r[gi][1:0], sync_pins[gi]};
          if (sync_s_r[gi][1] == sync_s_r[gi][2]) sync_f_r[gi] <= sync_s_r[gi][2];
          sync_d_r[gi] <= sync_f_r[gi];
        end
      end
    end
  endgenerate

  wire hs_edge = sync_f_r[0] & ~sync_d_r[0];
  wire vs_edge = sync_f_r[1] & ~sync_d_r[1];

  // ****************************************
  // Lines per frame counter
  // ****************************************
  reg [11:0] line_cnt_r;
  reg [11:0] lines_r;

  // Saturates rather than wraps, so a lost Vsync reads as a full count, not a small one.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt_r <= 12'h000;
      lines_r <= 12'h000;
    end else if (vs_edge) begin
      // R12 upper count latched
      lines_r <= line_cnt_r;
      line_cnt_r <= hs_edge ? 12'h001 : 12'h000;
    end else if (hs_edge && (line_cnt_r != `LINE_COUNT_MAX)) begin
      line_cnt_r <= line_cnt_r + 12'h001;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  reg [7:0] div_high_r;
  reg [7:0] div_low_r;
  reg [11:0] div_commit_r;
  reg [7:0] clkgen_r;
  reg [7:0] test_one_r;
  reg [7:0] test_two_r;
  reg [7:0] offset_hold_r;
  reg [7:0] test_five_r;
  reg [7:0] test_six_r;
  reg [7:0] gain_r;

  // Writes to read-only or unmapped offsets are dropped.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // R4 power-up ratio
      div_high_r <= `RST_DIV_HIGH;
      div_low_r <= `RST_DIV_LOW;
      div_commit_r <= `RST_DIVIDE_RATIO;
      clkgen_r <= `RST_CLKGEN_CTRL;
      test_one_r <= `RST_TEST_ONE;
      test_two_r <= `RST_TEST_TWO;
      offset_hold_r <= `RST_OFFSET_HOLD;
      test_five_r <= `RST_TEST_FIVE;
      test_six_r <= `RST_TEST_SIX;
      gain_r <= `RST_GAIN_MATCH;
    end else if (wr_stb) begin
      case (wr_addr)
        `OFS_DIV_HIGH: begin
          // R21 shadow only
          div_high_r <= wr_data;
        end
        `OFS_DIV_LOW: begin
          // R2 commit on low write
          div_low_r <= wr_data;
          // R1 twelve bit ratio
          div_commit_r <= {div_high_r, wr_data[`DIV_LOW_MSB:`DIV_LOW_LSB]};
        end
        `OFS_CLKGEN_CTRL: clkgen_r <= wr_data;
        `OFS_TEST_ONE: test_one_r <= wr_data;
        `OFS_TEST_TWO: test_two_r <= wr_data;
        `OFS_OFFSET_HOLD: offset_hold_r <= wr_data;
        `OFS_TEST_FIVE: test_five_r <= wr_data;
        `OFS_TEST_SIX: test_six_r <= wr_data;
        `OFS_GAIN_MATCH: gain_r <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  // Unmapped offsets read as zero.
  always @* begin
    case (rd_addr)
      // R20 revision
      `OFS_SILICON_REVISION: rd_data = REVISION;
      `OFS_DIV_HIGH: rd_data = div_high_r;
      `OFS_DIV_LOW: rd_data = div_low_r;
      `OFS_CLKGEN_CTRL: rd_data = clkgen_r;
      // R12 count high
      `OFS_LINES_HIGH: rd_data = lines_r[11:4];
      // R11 count low
      `OFS_LINES_LOW: rd_data = {lines_r[3:0], 4'h0};
      `OFS_TEST_ONE: rd_data = test_one_r;
      `OFS_TEST_TWO: rd_data = test_two_r;
      `OFS_TEST_RB_ONE: rd_data = `RST_TEST_READBACK;
      `OFS_TEST_RB_TWO: rd_data = `RST_TEST_READBACK;
      `OFS_OFFSET_HOLD: rd_data = offset_hold_r;
      `OFS_TEST_FIVE: rd_data = test_five_r;
      `OFS_TEST_SIX: rd_data = test_six_r;
      `OFS_GAIN_MATCH: rd_data = gain_r;
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // Clock generator controls
  // ****************************************
  wire [1:0] band_w = clkgen_r[`BAND_MSB:`BAND_LSB];
  wire [2:0] pump_w = clkgen_r[`PUMP_MSB:`PUMP_LSB];
  wire ext_w = clkgen_r[`EXT_CLK_BIT];

  // Outputs are registered copies so the analog side never sees a decode glitch.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_clock_divide_ratio <= `RST_DIVIDE_RATIO;
      pll_divider_enable <= 1'b1;
      phase_adjust_enable <= 1'b1;
      oscillator_band_select <= 2'h1;
      post_divider_log2 <= 2'h1;
      pump_current_code <= 3'h1;
      pump_current_ua <= 11'h064;
      external_pixel_clock_select <= 1'b0;
    end else begin
      // R3 lowest usable ratio
      if (div_commit_r < `DIV_MIN) pixel_clock_divide_ratio <= `DIV_MIN;
      else pixel_clock_divide_ratio <= div_commit_r;
      // R5 Hsync locked loop
      // R10 ratio ignored on external clock
      pll_divider_enable <= ~ext_w;
      phase_adjust_enable <= 1'b1;
      // R9 clock source
      external_pixel_clock_select <= ext_w;
      // R6 band select
      oscillator_band_select <= band_w;
      // R7 automatic post divider
      case (band_w)
        2'h0: post_divider_log2 <= 2'h2;
        2'h1: post_divider_log2 <= 2'h1;
        default: post_divider_log2 <= 2'h0;
      endcase
      // R8 pump current table
      pump_current_code <= pump_w;
      case (pump_w)
        3'h0: pump_current_ua <= 11'h032;
        3'h1: pump_current_ua <= 11'h064;
        3'h2: pump_current_ua <= 11'h096;
        3'h3: pump_current_ua <= 11'h0FA;
        3'h4: pump_current_ua <= 11'h15E;
        3'h5: pump_current_ua <= 11'h1F4;
        3'h6: pump_current_ua <= 11'h2EE;
        default: pump_current_ua <= 11'h5DC;
      endcase
    end
  end

  // ****************************************
  // Calibration controls
  // ****************************************
  // Test settings pass through; the host must load the required values.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_offset_continuous <= 1'b0;
      gain_matching_continuous <= 1'b0;
      gain_matching_enable <= 1'b0;
      test_setting_one <= `RST_TEST_ONE;
      test_setting_two <= `RST_TEST_TWO;
      test_setting_five <= `RST_TEST_FIVE;
      test_setting_six <= `RST_TEST_SIX;
    end else begin
      // R15 offset update mode
      auto_offset_continuous <= offset_hold_r[`OFFSET_CONT_BIT];
      // R17 gain hold
      gain_matching_continuous <= gain_r[`GAIN_HOLD_BIT];
      // R18 gain enable code
      gain_matching_enable <= (gain_r[`GAIN_EN_MSB:`GAIN_EN_LSB] == `GAIN_EN_CODE);
      // R13 test values passed on
      test_setting_one <= test_one_r;
      test_setting_two <= test_two_r;
      // R14 test values passed on
      test_setting_five <= test_five_r;
      test_setting_six <= test_six_r;
    end
  end

endmodule
`default_nettype wire

// file: sim/video_adc_regs_assertions.sv
// Concurrent checks on the ports of the clock and calibration register bank.
`timescale 1ns/1ps
`default_nettype none

module video_adc_regs_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic [11:0] pixel_clock_divide_ratio,
  input wire logic pll_divider_enable,
  input wire logic phase_adjust_enable,
  input wire logic [1:0] oscillator_band_select,
  input wire logic [1:0] post_divider_log2,
  input wire logic [2:0] pump_current_code,
  input wire logic [10:0] pump_current_ua,
  input wire logic external_pixel_clock_select,
  input wire logic auto_offset_continuous,
  input wire logic gain_matching_continuous,
  input wire logic gain_matching_enable
);
  // Pump current in microamps, indexed by the three-bit code.
  localparam logic [10:0] UA [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
                                     11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ****************************************
  // Sequences
  // ****************************************
  // First sampled edge after the reset pin is let go.
  sequence released;
    $rose(arst_n);
  endsequence
  // Settings move late in a low clock phase.
  sequence in_scl_low;
    !scl_in && !$past(scl_in, 4);
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  chk_ratio_commit: assert property ($changed(pixel_clock_divide_ratio) |-> in_scl_low)
    else $error("divide ratio moved outside a byte commit");
  chk_ratio_floor: assert property (pixel_clock_divide_ratio >= 12'h002)
    else $error("divide ratio below two");
  chk_reset_ratio: assert property (released |-> pixel_clock_divide_ratio == 12'h69D)
    else $error("divide ratio not at its power-up value");
  chk_reset_clkgen: assert property (released |-> oscillator_band_select == 2'h1
      && pump_current_code == 3'h1 && !external_pixel_clock_select)
    else $error("clock generator fields not at power-up values");
  chk_post_div_map: assert property ($stable(oscillator_band_select) |->
      post_divider_log2 == (oscillator_band_select == 2'h0 ? 2'h2 :
                            oscillator_band_select == 2'h1 ? 2'h1 : 2'h0))
    else $error("post divider does not follow the band");
  chk_pump_decode: assert property ($stable(pump_current_code) |->
      pump_current_ua == UA[pump_current_code])
    else $error("pump current does not match its code");
  chk_ext_pll_link: assert property ($stable(external_pixel_clock_select) |->
      pll_divider_enable == !external_pixel_clock_select)
    else $error("divider enable disagrees with clock source");
  chk_phase_kept: assert property (phase_adjust_enable)
    else $error("phase adjustment dropped");
  chk_calib_commit: assert property ($changed({auto_offset_continuous,
      gain_matching_continuous, gain_matching_enable}) |-> in_scl_low)
    else $error("calibration control moved outside a byte commit");
  chk_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line drive changed while serial clock high");
endmodule

bind video_adc_clock_calib_regs video_adc_regs_checker chk (.*);
`default_nettype wire

// file: sim/serial_host_model.sv
// Host controller model that drives the two-wire serial control port.
`timescale 1ns/1ps
`default_nettype none
`include "video_adc_regs.vh"

module serial_host_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // Idle bus: clock high, data released to its pull-up.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Pins move at falling edges; 8-cycle phases beat the 5-cycle minimum.
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bit: data placed while the clock is low, sampled at the end of the high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    idle(HALF);
    scl = 1'b1;
    idle(HALF);
    r = sda_line;
    scl = 1'b0;
    idle(4);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    sda_pull = 1'b0;
    idle(HALF);
    scl = 1'b1;
    idle(HALF);
    sda_pull = 1'b1;
    idle(HALF);
    scl = 1'b0;
    idle(4);
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop_cond();
    sda_pull = 1'b1;
    idle(HALF);
    scl = 1'b1;
    idle(HALF);
    sda_pull = 1'b0;
    idle(HALF);
  endtask

  // Eight bits most significant first, then the acknowledge slot.
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, nak);
  endtask

  // Register write: device address, pointer, one data byte.
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic nak);
    logic [7:0] rx;
    logic n0, n1, n2;
    start_cond();
    byte_io({`SERIAL_DEV_ADDR, 1'b0}, rx, n0);
    byte_io(ptr, rx, n1);
    byte_io(data, rx, n2);
    stop_cond();
    nak = n0 | n1 | n2;
  endtask

  // Register read: pointer set, repeated start, one byte closed by a host NACK.
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic nak);
    logic n0, n1, n2, dn;
    start_cond();
    byte_io({`SERIAL_DEV_ADDR, 1'b0}, data, n0);
    byte_io(ptr, data, n1);
    start_cond();
    byte_io({`SERIAL_DEV_ADDR, 1'b1}, data, n2);
    byte_io(8'hFF, data, dn);
    stop_cond();
    nak = n0 | n1 | n2;
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking testbench of the clock and calibration register bank.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsync_in = 1'b0;
  logic vsync_in = 1'b0;
  logic scl, sda_pull;
  wire logic sda_out, sda_oe, sda_line;
  wire logic [11:0] ratio;
  wire logic pll_en, phase_en, ext_sel, offs_cont, gain_cont, gain_en;
  wire logic [1:0] band, post_div;
  wire logic [2:0] pump;
  wire logic [10:0] ua;
  wire logic [7:0] t1, t2, t5, t6;
  int err_count = 0;
  int n_tests = 0;
  // Arbitrary revision value for this bench.
  localparam logic [7:0] REV = 8'hA5;
  localparam logic [10:0] UA [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
                                     11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};

  // Open-drain data wire with pull-up.
  assign sda_line = !((sda_oe && !sda_out) || sda_pull);

  always #12.5 clk = ~clk;

  video_adc_clock_calib_regs #(.REVISION(REV)) uut (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .hsync_in(hsync_in), .vsync_in(vsync_in),
    .pixel_clock_divide_ratio(ratio), .pll_divider_enable(pll_en),
    .phase_adjust_enable(phase_en), .oscillator_band_select(band),
    .post_divider_log2(post_div), .pump_current_code(pump), .pump_current_ua(ua),
    .external_pixel_clock_select(ext_sel), .auto_offset_continuous(offs_cont),
    .gain_matching_continuous(gain_cont), .gain_matching_enable(gain_en),
    .test_setting_one(t1), .test_setting_two(t2),
    .test_setting_five(t5), .test_setting_six(t6)
  );

  serial_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // ****************************************
  // Checking and bus helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic nak;
    host.write_reg(ptr, data, nak);
    check("write ack", 16'(nak), 16'h0000);
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic nak;
    logic [7:0] data;
    host.read_reg(ptr, data, nak);
    check("read ack", 16'(nak), 16'h0000);
    check("read data", 16'(data), 16'(exp));
  endtask

  task automatic sync_pulse(input logic is_v);
    {vsync_in, hsync_in} = is_v ? 2'h2 : 2'h1;
    repeat (4) @(negedge clk);
    {vsync_in, hsync_in} = 2'h0;
    repeat (4) @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Power-up values at the pins and through the serial port.
  task automatic t_reset_values();
    check("ratio", 16'(ratio), 16'h069D);
    check("clock fields", {ext_sel, pll_en, band, pump}, 16'h0029);
    check("pump ua", 16'(ua), 16'h0064);
    rd(8'h01, 8'h69);
    rd(8'h00, REV);
    wr(8'h00, 8'h3C);
    rd(8'h00, REV);
    rd(8'h2C, 8'h00);
    rd(8'h3C, 8'h00);
  endtask

  // High bits wait in the shadow until the low commit.
  task automatic t_divider_commit();
    wr(8'h01, 8'hAB);
    check("ratio held", 16'(ratio), 16'h069D);
    rd(8'h01, 8'hAB);
    wr(8'h02, 8'hC5);
    check("ratio commit", 16'(ratio), 16'h0ABC);
    wr(8'h01, 8'hFF);
    wr(8'h02, 8'hF0);
    check("ratio max", 16'(ratio), 16'h0FFF);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h20);
    check("ratio min", 16'(ratio), 16'h0002);
  endtask

  // Every band and pump code, alternating the clock source.
  task automatic t_clkgen();
    logic [1:0] b;
    logic [1:0] pd;
    for (int i = 0; i < 8; i++) begin
      b = 2'(i);
      pd = (b == 2'h0) ? 2'h2 : (b == 2'h1) ? 2'h1 : 2'h0;
      wr(8'h03, {b, 3'(i), i[0], 2'h0});
      check("band", 16'(band), 16'(b));
      check("post div", 16'(post_div), 16'(pd));
      check("pump ua", 16'(ua), 16'(UA[i]));
      check("source", {ext_sel, pll_en, phase_en}, {14'(i[0]), !i[0], 1'b1});
    end
  endtask

  // Offset hold and gain matching controls.
  task automatic t_calib();
    wr(8'h2C, 8'h10);
    check("offset", 16'(offs_cont), 16'h0001);
    wr(8'h3C, 8'h0E);
    check("gain", {gain_cont, gain_en}, 16'h0003);
    wr(8'h3C, 8'h06);
    check("gain", {gain_cont, gain_en}, 16'h0001);
    wr(8'h3C, 8'h08);
    check("gain", {gain_cont, gain_en}, 16'h0002);
    wr(8'h2C, 8'h00);
    check("offset", 16'(offs_cont), 16'h0000);
  endtask

  // Required test values, then read-only and unmapped places.
  task automatic t_test_regs();
    check("test resets", {t5, t6}, 16'hF0F0);
    // host loads the first two test registers
    wr(8'h28, 8'hBF);
    wr(8'h29, 8'h02);
    // host loads the last two test registers
    wr(8'h2D, 8'hE8);
    wr(8'h2E, 8'hE0);
    check("tests one two", {t1, t2}, 16'hBF02);
    check("tests five six", {t5, t6}, 16'hE8E0);
    wr(8'h2A, 8'h55);
    rd(8'h2A, 8'h00);
    rd(8'h50, 8'h00);
  endtask

  // 37 lines between two frame pulses.
  task automatic t_line_count();
    sync_pulse(1'b1);
    repeat (37) sync_pulse(1'b0);
    sync_pulse(1'b1);
    rd(8'h26, 8'h02);
    wr(8'h27, 8'hFF);
    rd(8'h27, 8'h50);
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_reset_values();
    t_divider_commit();
    t_clkgen();
    t_calib();
    t_test_regs();
    t_line_count();
    give_verdict();
  end
endmodule
`default_nettype wire
